/* inc/lp_cmd_pkg.sv */
// shared constants and types for the printer command decoder
package lp_cmd_pkg;
    // low-bit patterns (bits 5-7 of the byte, bits 2..0 in vector order)
    localparam logic [2:0] LOW_WRITE = 3'h1; // write: bits 5-7 = 001
    localparam logic [2:0] LOW_CTRL = 3'h3; // control: bits 5-7 = 011
    // spacing field bits 0-4: 0..3 lines, 16+channel for skip
    localparam logic [4:0] FLD_NOSPACE = 5'h00;
    localparam logic [4:0] FLD_SPACE3 = 5'h03;
    localparam logic [4:0] FLD_SKIP_BASE = 5'h10;
    localparam logic [4:0] FLD_SKIP_CH1 = 5'h11;
    localparam logic [4:0] FLD_SKIP_CH12 = 5'h1C;
    // control bytes with no motion
    localparam logic [7:0] CMD_NOOP = 8'h03;
    localparam logic [7:0] CMD_BLOCK_CHK = 8'h73;
    localparam logic [7:0] CMD_ALLOW_CHK = 8'h7B;
    localparam logic [7:0] CMD_GATE_LOAD = 8'hEB;
    localparam logic [7:0] CMD_MCS_FOLD = 8'hF3;
    localparam logic [7:0] CMD_MCS_NOFOLD = 8'hFB;
    localparam logic [7:0] CMD_SENSE = 8'h04;
    localparam logic BLOCK_CHK_RST = 1'b0;
    localparam logic [5:0] GRAPHIC_MASK = 6'h3F;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_WRITE = 4'h1,
        OP_SPACE = 4'h2,
        OP_SKIP = 4'h3,
        OP_NOOP = 4'h4,
        OP_BLOCK_CHK = 4'h5,
        OP_ALLOW_CHK = 4'h6,
        OP_GATE_LOAD = 4'h7,
        OP_MCS_FOLD = 4'h8,
        OP_MCS_NOFOLD = 4'h9,
        OP_SENSE = 4'hA,
        OP_INVALID = 4'hB
    } op_t;

    // decoded command carried as one bundle
    typedef struct packed {
        op_t op;
        logic print;
        logic [1:0] after_lines;
        logic [3:0] after_channel;
        logic after_skip;
        logic [1:0] now_lines;
        logic [3:0] now_channel;
        logic now_skip;
    } cmd_t;
endpackage

/* hw/lp_graphic_fold.sv */
// graphic fold: print codes differing only in bits 0-1 share a graphic
module lp_graphic_fold
    import lp_cmd_pkg::*;
(
    input wire logic [7:0] code_i,
    output logic [5:0] graphic_o
);
    // columns 0X, 4X, 8X and CX collapse onto one graphic
    assign graphic_o = code_i[5:0] & GRAPHIC_MASK;
endmodule

/* hw/line_printer_command_decoder.sv */
// command byte decoder for the line printer attachment
// What this block does
// - Byte 01 starts a print-line write with no carriage motion after it.
// - Bytes 09, 11 and 19 print and then space one, two or three lines.
// - Write with skip has low bits 001 and bits 0-4 of sixteen plus channel.
// - Byte E1 prints then skips to channel twelve, the highest skip code.
// - Bytes 0B, 13 and 1B space one, two or three lines without printing.
// - Immediate skip has low bits 011, channel field 11 to 1C, no printing.
// - Byte 03 is a no-op with no printing and no motion.
// - Byte 73 blocks print data checks, with no printing or motion.
// - Byte 7B allows print data checks again, with no printing or motion.
// - Byte EB performs gate load, with no printing or motion.
// - Byte F3 loads the multi charset table with lower-case folding.
// - Byte FB loads the multi charset table without folding.
// - Byte 04 returns sense information instead of printing.
// - Print codes with equal low six bits select the same graphic.
module line_printer_command_decoder
    import lp_cmd_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_byte_i,
    input wire logic [7:0] print_code_i,
    output logic cmd_done_o,
    output cmd_t cmd_o,
    output logic invalid_o,
    output logic block_chk_o,
    output logic fold_o,
    output logic [5:0] graphic_o
);
    cmd_t dec;
    cmd_t cmd_ff;
    cmd_t nxt_cmd;
    logic done_ff;
    logic nxt_done;
    logic inv_ff;
    logic nxt_inv;
    logic blk_ff;
    logic nxt_blk;
    logic fold_ff;
    logic nxt_fold;
    logic [5:0] gr_ff;
    logic [5:0] nxt_gr;
    logic [5:0] gr_comb;
    logic [4:0] fld;
    logic [2:0] low;

    assign fld = cmd_byte_i[7:3];
    assign low = cmd_byte_i[2:0];

    // pure decode of the byte; anything unmatched falls to invalid
    always_comb
    begin
        dec = '0;
        dec.op = OP_INVALID;
        if (low == LOW_WRITE && fld <= FLD_SPACE3)
        begin
            dec.op = OP_WRITE;
            dec.print = 1'b1;
            dec.after_lines = fld[1:0];
        end
        else if (low == LOW_WRITE && fld >= FLD_SKIP_CH1
                 && fld <= FLD_SKIP_CH12)
        begin
            dec.op = OP_WRITE;
            dec.print = 1'b1;
            dec.after_skip = 1'b1;
            dec.after_channel = fld[3:0];
        end
        else if (low == LOW_CTRL && fld != FLD_NOSPACE
                 && fld <= FLD_SPACE3)
        begin
            dec.op = OP_SPACE;
            dec.now_lines = fld[1:0];
        end
        else if (low == LOW_CTRL && fld >= FLD_SKIP_CH1
                 && fld <= FLD_SKIP_CH12)
        begin
            dec.op = OP_SKIP;
            dec.now_skip = 1'b1;
            dec.now_channel = fld[3:0];
        end
        else
        begin
            case (cmd_byte_i)
                CMD_NOOP: dec.op = OP_NOOP;
                CMD_BLOCK_CHK: dec.op = OP_BLOCK_CHK;
                CMD_ALLOW_CHK: dec.op = OP_ALLOW_CHK;
                CMD_GATE_LOAD: dec.op = OP_GATE_LOAD;
                CMD_MCS_FOLD: dec.op = OP_MCS_FOLD;
                CMD_MCS_NOFOLD: dec.op = OP_MCS_NOFOLD;
                CMD_SENSE: dec.op = OP_SENSE;
                default: dec.op = OP_INVALID;
            endcase
        end
    end

    lp_graphic_fold u_fold (
        .code_i(print_code_i),
        .graphic_o(gr_comb)
    );

    // next state: result is registered one cycle after the byte is taken;
    // the check-block and fold modes persist until changed by a command
    always_comb
    begin
        nxt_cmd = cmd_ff;
        nxt_done = 1'b0;
        nxt_inv = 1'b0;
        nxt_blk = blk_ff;
        nxt_fold = fold_ff;
        nxt_gr = gr_comb;
        if (cmd_valid_i)
        begin
            nxt_cmd = dec;
            nxt_done = 1'b1;
            nxt_inv = (dec.op == OP_INVALID);
            if (dec.op == OP_BLOCK_CHK)
                nxt_blk = 1'b1;
            if (dec.op == OP_ALLOW_CHK)
                nxt_blk = 1'b0;
            if (dec.op == OP_MCS_FOLD)
                nxt_fold = 1'b1;
            if (dec.op == OP_MCS_NOFOLD)
                nxt_fold = 1'b0;
        end
    end

    // registers only
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cmd_ff <= '0;
            done_ff <= 1'b0;
            inv_ff <= 1'b0;
            blk_ff <= BLOCK_CHK_RST;
            fold_ff <= 1'b0;
            gr_ff <= '0;
        end
        else
        begin
            cmd_ff <= nxt_cmd;
            done_ff <= nxt_done;
            inv_ff <= nxt_inv;
            blk_ff <= nxt_blk;
            fold_ff <= nxt_fold;
            gr_ff <= nxt_gr;
        end
    end

    assign cmd_done_o = done_ff;
    assign cmd_o = cmd_ff;
    assign invalid_o = inv_ff;
    assign block_chk_o = blk_ff;
    assign fold_o = fold_ff;
    assign graphic_o = gr_ff;

    // checks, each answered on the edge after the byte is taken, except a_block_hold, answered on the second edge
    a_write_nospace: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cmd_valid_i && cmd_byte_i == 8'h01 |=> cmd_o.op == OP_WRITE
        && cmd_o.print && cmd_o.after_lines == 2'h0 && !cmd_o.after_skip)
        else $error("write no space decoded wrong");
    a_write_space: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cmd_valid_i && cmd_byte_i == 8'h19 |=> cmd_o.after_lines == 2'h3
        && cmd_o.print)
        else $error("write space three decoded wrong");
    a_write_skip: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cmd_valid_i && cmd_byte_i == 8'h89 |=> cmd_o.after_skip
        && cmd_o.after_channel == 4'h1)
        else $error("write skip channel one wrong");
    a_skip_twelve: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cmd_valid_i && cmd_byte_i == 8'hE1 |=> cmd_o.after_channel == 4'hC)
        else $error("skip twelve wrong");
    a_space_now: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cmd_valid_i && cmd_byte_i == 8'h13 |=> cmd_o.op == OP_SPACE
        && cmd_o.now_lines == 2'h2 && !cmd_o.print)
        else $error("immediate space wrong");
    a_skip_now: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cmd_valid_i && cmd_byte_i == 8'hE3 |=> cmd_o.now_skip
        && cmd_o.now_channel == 4'hC && !cmd_o.print)
        else $error("immediate skip wrong");
    a_noop_still: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cmd_valid_i && cmd_byte_i == CMD_NOOP |=> cmd_o.op == OP_NOOP
        && !cmd_o.print && !cmd_o.now_skip && cmd_o.now_lines == 2'h0)
        else $error("no-op moved");
    a_block_hold: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cmd_valid_i && cmd_byte_i == CMD_BLOCK_CHK ##1
        !(cmd_valid_i && cmd_byte_i == CMD_ALLOW_CHK) |=> block_chk_o)
        else $error("block check lost");
    a_allow_chk: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cmd_valid_i && cmd_byte_i == CMD_ALLOW_CHK |=> !block_chk_o)
        else $error("allow check failed");
    a_gate_load: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cmd_valid_i && cmd_byte_i == CMD_GATE_LOAD |=>
        cmd_o.op == OP_GATE_LOAD)
        else $error("gate load wrong");
    a_mcs_fold: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cmd_valid_i && cmd_byte_i == CMD_MCS_FOLD |=> fold_o
        && cmd_o.op == OP_MCS_FOLD)
        else $error("fold load wrong");
    a_mcs_nofold: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cmd_valid_i && cmd_byte_i == CMD_MCS_NOFOLD |=> !fold_o)
        else $error("no fold load wrong");
    a_sense_cmd: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cmd_valid_i && cmd_byte_i == CMD_SENSE |=> cmd_o.op == OP_SENSE
        && !cmd_o.print)
        else $error("sense wrong");
    a_graphic_fold: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        1'b1 |=> graphic_o == $past(print_code_i[5:0]))
        else $error("graphic fold wrong");
    a_invalid_cmd: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cmd_valid_i && cmd_byte_i == 8'hE9 |=> invalid_o && !cmd_o.print)
        else $error("invalid byte accepted");
endmodule

/* tb/chan_model.sv */
// channel-side model that issues command bytes to the decoder
module chan_model
(
    input wire logic clock_i,
    output logic cmd_valid_o,
    output logic [7:0] cmd_byte_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet at time zero, before reset lets any byte through
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_byte_o = 8'h00;
    end

    // one byte per call, launched just after an edge, held across the next
    task automatic issue(input logic [7:0] b);
        @(posedge clock_i);
        #1;
        cmd_valid_o = 1'b1;
        cmd_byte_o = b;
    endtask

    // released lines show the inverse of the last byte, so no stale match
    task automatic idle();
        @(posedge clock_i);
        #1;
        cmd_valid_o = 1'b0;
        cmd_byte_o = ~cmd_byte_o;
    endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the printer command decoder
module tb
    import lp_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i;
    logic rst_b_i;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic [7:0] print_code;
    logic cmd_done;
    cmd_t cmd;
    logic invalid;
    logic block_chk;
    logic fold;
    logic [5:0] graphic;
    logic exp_blk;
    logic exp_fold;
    int fail_count;
    int tests_run;

    chan_model chan_u (
        .clock_i(clock_i),
        .cmd_valid_o(cmd_valid),
        .cmd_byte_o(cmd_byte)
    );

    line_printer_command_decoder dut_u (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .cmd_valid_i(cmd_valid),
        .cmd_byte_i(cmd_byte),
        .print_code_i(print_code),
        .cmd_done_o(cmd_done),
        .cmd_o(cmd),
        .invalid_o(invalid),
        .block_chk_o(block_chk),
        .fold_o(fold),
        .graphic_o(graphic)
    );

    // 50 MHz clock
    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // decode worked out from the byte layout; bit 7 of the vector leads
    function automatic cmd_t expect_cmd(input logic [7:0] b);
        cmd_t c;
        logic [4:0] f;
        logic sk;
        c = '0;
        f = b[7:3];
        sk = (f >= FLD_SKIP_CH1) && (f <= FLD_SKIP_CH12);
        c.op = OP_INVALID;
        if (b[2:0] == LOW_WRITE && (f <= FLD_SPACE3 || sk))
        begin
            c.op = OP_WRITE;
            c.print = 1'b1;
            c.after_lines = sk ? 2'h0 : f[1:0];
            c.after_skip = sk;
            c.after_channel = sk ? f[3:0] : 4'h0;
        end
        else if (b[2:0] == LOW_CTRL && (sk || (f != 5'h00 && f <= 5'h03)))
        begin
            c.op = sk ? OP_SKIP : OP_SPACE;
            c.now_lines = sk ? 2'h0 : f[1:0];
            c.now_skip = sk;
            c.now_channel = sk ? f[3:0] : 4'h0;
        end
        else if (b == CMD_NOOP)
            c.op = OP_NOOP;
        else if (b == CMD_BLOCK_CHK)
            c.op = OP_BLOCK_CHK;
        else if (b == CMD_ALLOW_CHK)
            c.op = OP_ALLOW_CHK;
        else if (b == CMD_GATE_LOAD)
            c.op = OP_GATE_LOAD;
        else if (b == CMD_MCS_FOLD)
            c.op = OP_MCS_FOLD;
        else if (b == CMD_MCS_NOFOLD)
            c.op = OP_MCS_NOFOLD;
        else if (b == CMD_SENSE)
            c.op = OP_SENSE;
        return c;
    endfunction

    // judge the answer to byte b, seen one edge after it was taken
    task automatic judge(input logic [7:0] b);
        cmd_t e;
        e = expect_cmd(b);
        exp_blk = (b == 8'h73) ? 1'b1 : ((b == 8'h7B) ? 1'b0 : exp_blk);
        exp_fold = (b == 8'hF3) ? 1'b1 : ((b == 8'hFB) ? 1'b0 : exp_fold);
        check(32'(cmd_done), 32'h1);
        check(32'(invalid), 32'(e.op == OP_INVALID));
        check(32'(block_chk), 32'(exp_blk));
        check(32'(fold), 32'(exp_fold));
        if (e.op == OP_WRITE)
            check(32'(cmd), 32'(e));
        else if (e.op == OP_SPACE || e.op == OP_SKIP)
            check(32'(cmd), 32'(e));
        else
            check(32'(cmd), 32'(e));
    endtask

    // every byte value, back to back, each answered on the next edge
    task automatic run_sweep();
        for (int k = 0; k < 256; k++)
        begin
            chan_u.issue(8'(k));
            if (k > 0)
                judge(8'(k - 1));
        end
        chan_u.idle();
        judge(8'hFF);
        @(posedge clock_i);
        #1;
        check(32'({cmd_done, invalid}), 32'h0);
    endtask

    // mode flags hold while idle, then clear on a mid-run reset
    task automatic run_modes_reset();
        chan_u.issue(CMD_BLOCK_CHK);
        chan_u.issue(CMD_MCS_FOLD);
        judge(CMD_BLOCK_CHK);
        chan_u.idle();
        judge(CMD_MCS_FOLD);
        @(posedge clock_i);
        #1;
        check(32'({cmd_done, block_chk, fold}), 32'h3);
        rst_b_i = 1'b0;
        #1;
        check(32'({block_chk, fold, cmd}), 32'h0);
        @(posedge clock_i);
        #1;
        rst_b_i = 1'b1;
        exp_blk = 1'b0;
        exp_fold = 1'b0;
    endtask

    // codes 0X, 4X, 8X and CX must land on the same graphic
    task automatic run_graphic();
        for (int k = 0; k <= 256; k++)
        begin
            @(posedge clock_i);
            #1;
            if (k > 0)
                check(32'(graphic), 32'((k - 1) % 64));
            print_code = 8'(k);
        end
    endtask

    // watchdog sized well above the roughly 540 cycles of the run
    initial
    begin
        #40000;
        fail_count++;
        end_of_test();
    end

    initial
    begin
        fail_count = 0;
        tests_run = 0;
        exp_blk = 1'b0;
        exp_fold = 1'b0;
        print_code = 8'h00;
        rst_b_i = 1'b0;
        repeat (16) @(posedge clock_i);
        #1;
        rst_b_i = 1'b1;
        check(32'({cmd_done, block_chk, fold, cmd}), 32'h0);
        run_sweep();
        run_modes_reset();
        run_graphic();
        end_of_test();
    end
endmodule
